// ### src/tcm_defines.vh
// offsets, field positions and reset values of the port controller register bank
`ifndef TCM_DEFINES_VH
`define TCM_DEFINES_VH
`define TCM_OFS_MANUAL 8'h09
`define TCM_OFS_SWRST 8'h0a
`define TCM_OFS_MASK_MAIN 8'h0e
`define TCM_OFS_MASK_REC 8'h0f
`define TCM_OFS_STAT_MAIN 8'h11
`define TCM_OFS_STAT_REC 8'h12
`define TCM_OFS_KIND 8'h13
`define TCM_OFS_FLAG_MAIN 8'h14
`define TCM_OFS_FLAG_REC 8'h15
`define TCM_MAN_ERR_REC 0
`define TCM_MAN_DISABLE 1
`define TCM_MAN_UNATT_SOURCE 2
`define TCM_MAN_UNATT_SINK 3
`define TCM_MAN_FORCE_SINK 4
`define TCM_MAN_FORCE_SOURCE 5
`define TCM_SWRST_BIT 0
`define TCM_FM_ATTACH 0
`define TCM_FM_DETACH 1
`define TCM_FM_LEVEL 2
`define TCM_FM_WEAKBATT 3
`define TCM_FM_BUSPWR 4
`define TCM_FM_FAULT 5
`define TCM_FM_ORIENT 6
`define TCM_FR_REMEDY 0
`define TCM_FR_FRC_OK 1
`define TCM_FR_FRC_BAD 2
`define TCM_FR_REM_BAD 3
`define TCM_FR_PWR_UP 5
`define TCM_FR_PWR_OFF 6
`define TCM_MAIN_IMPL 8'h7f
`define TCM_REC_IMPL 8'h6f
`define TCM_RST_MASK 8'h00
`define TCM_RST_FLAGS 8'h00
`define TCM_RST_MANUAL 8'h00
`define TCM_OR_NONE 2'h0
`define TCM_OR_CC1 2'h1
`define TCM_OR_CC2 2'h2
`endif

// ### src/tcm_i2c_target.v
// i2c target that turns bus transfers into register reads and writes
`timescale 1ns/10ps
`include "tcm_defines.vh"
module tcm_i2c_target #(
  parameter [6:0] ADDR = 7'h21
) (
  input wire clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output reg [7:0] reg_addr,
  output reg wr_stb,
  output reg [7:0] wr_data,
  input wire [7:0] rd_data
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_PTR = 3'h2;
  localparam [2:0] ST_WDAT = 3'h3;
  localparam [2:0] ST_RDAT = 3'h4;
  reg scl_s1, scl_s2, scl_d;
  reg sda_s1, sda_s2, sda_d;
  reg [2:0] state_r;
  reg [3:0] cnt_r;
  reg [7:0] sh_r;
  reg rw_r;
  reg nack_r;
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_s1 <= 1'h1;
      scl_s2 <= 1'h1;
      scl_d <= 1'h1;
      sda_s1 <= 1'h1;
      sda_s2 <= 1'h1;
      sda_d <= 1'h1;
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      rw_r <= 1'h0;
      nack_r <= 1'h0;
      sda_out <= 1'h0;
      sda_oe <= 1'h0;
      reg_addr <= 8'h00;
      wr_stb <= 1'h0;
      wr_data <= 8'h00;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      sda_out <= 1'h0;
      wr_stb <= 1'h0;
      if (start_c) begin
        state_r <= ST_ADDR;
        cnt_r <= 4'h0;
        sda_oe <= 1'h0;
      end else if (stop_c) begin
        state_r <= ST_IDLE;
        sda_oe <= 1'h0;
      end else if (state_r == ST_RDAT) begin
        if (scl_rise) begin
          if (cnt_r == 4'h8) begin
            nack_r <= sda_s2;
            cnt_r <= 4'h9;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end else if (scl_fall) begin
          if (cnt_r == 4'h9) begin
            if (nack_r) begin
              state_r <= ST_IDLE;
            end else begin
              sh_r <= rd_data;
              sda_oe <= ~rd_data[7];
              reg_addr <= reg_addr + 8'h01;
              cnt_r <= 4'h0;
            end
          end else if (cnt_r == 4'h8) begin
            sda_oe <= 1'h0;
          end else begin
            sh_r <= {sh_r[6:0], 1'h0};
            sda_oe <= ~sh_r[6];
          end
        end
      end else if (state_r != ST_IDLE) begin
        if (scl_rise && cnt_r < 4'h8) begin
          sh_r <= {sh_r[6:0], sda_s2};
          cnt_r <= cnt_r + 4'h1;
        end else if (scl_fall && cnt_r == 4'h8) begin
          cnt_r <= 4'h9;
          case (state_r)
            ST_ADDR: begin
              if (sh_r[7:1] == ADDR) begin
                rw_r <= sh_r[0];
                sda_oe <= 1'h1;
              end else begin
                state_r <= ST_IDLE;
              end
            end
            ST_PTR: begin
              reg_addr <= sh_r;
              sda_oe <= 1'h1;
            end
            default: begin
              wr_stb <= 1'h1;
              wr_data <= sh_r;
              sda_oe <= 1'h1;
            end
          endcase
        end else if (scl_fall && cnt_r == 4'h9) begin
          cnt_r <= 4'h0;
          sda_oe <= 1'h0;
          if (state_r == ST_ADDR && rw_r) begin
            state_r <= ST_RDAT;
            sh_r <= rd_data;
            sda_oe <= ~rd_data[7];
            reg_addr <= reg_addr + 8'h01;
          end else if (state_r == ST_ADDR) begin
            state_r <= ST_PTR;
          end else if (state_r == ST_WDAT) begin
            reg_addr <= reg_addr + 8'h01;
          end else begin
            state_r <= ST_WDAT;
          end
        end
      end
    end
  end
endmodule

// ### src/tcm_regs.v
// control, status and interrupt register bank of the port controller
`timescale 1ns/10ps
`include "tcm_defines.vh"
module tcm_regs #(
  parameter [6:0] I2C_ADDR = 7'h21
) (
  input wire clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  output reg int_n_out,
  output reg int_n_oe,
  input wire bus_power_safe_zero,
  input wire bus_power_valid,
  input wire weak_batt_sink_active,
  input wire [1:0] orientation,
  input wire [1:0] advertised_current_level,
  input wire attached,
  input wire [6:0] partner_kind,
  input wire cc_over_rd_fault,
  input wire recovery_active,
  input wire recovery_power_off_req,
  input wire recovery_power_on_req,
  input wire recovery_failed_in,
  input wire force_executed,
  input wire force_rejected,
  input wire portrole_changed,
  input wire global_irq_mask,
  output reg disable_req,
  output reg error_recovery_cmd,
  output reg force_source_cmd,
  output reg force_sink_cmd,
  output reg go_unattached_source_cmd,
  output reg go_unattached_sink_cmd,
  output reg portrole_apply,
  output reg software_reset_bit
);
  wire [7:0] bus_addr;
  wire bus_wr;
  wire [7:0] bus_wdata;
  reg [7:0] rd_data_r;
  reg [1:0] pwr_s1;
  reg [1:0] pwr_s2;
  reg [7:0] mask_main_r;
  reg [7:0] mask_rec_r;
  reg [7:0] flags_main_r;
  reg [7:0] flags_rec_r;
  reg [1:0] orient_q;
  reg [1:0] level_q;
  reg [1:0] pwr_q;
  reg attached_q;
  reg weak_q;
  reg fault_q;
  reg remedy_q;
  reg role_pend_r;

  // address decode shared by every write path
  function wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = wr & (addr == ofs);
    end
  endfunction

  // sticky flag update where a new event beats a same-cycle clear
  function [7:0] flag_nxt;
    input [7:0] cur;
    input [7:0] clr;
    input [7:0] ev;
    input [7:0] impl;
    begin
      flag_nxt = ((cur & ~clr) | ev) & impl;
    end
  endfunction

  tcm_i2c_target #(
    .ADDR(I2C_ADDR)
  ) u_i2c (
    .clk(clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_addr(bus_addr),
    .wr_stb(bus_wr),
    .wr_data(bus_wdata),
    .rd_data(rd_data_r)
  );

  // analog comparator levels are asynchronous to clk
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pwr_sync
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          pwr_s1[gi] <= 1'h0;
          pwr_s2[gi] <= 1'h0;
        end else begin
          pwr_s1[gi] <= gi == 0 ? bus_power_valid : bus_power_safe_zero;
          pwr_s2[gi] <= pwr_s1[gi];
        end
      end
    end
  endgenerate

  wire pwr_valid = pwr_s2[0];
  wire pwr_safe_zero = pwr_s2[1];

  wire man_wr = wr_hit(bus_wr, bus_addr, `TCM_OFS_MANUAL);
  wire swrst_wr = wr_hit(bus_wr, bus_addr, `TCM_OFS_SWRST) & bus_wdata[`TCM_SWRST_BIT];
  wire [7:0] clr_main = wr_hit(bus_wr, bus_addr, `TCM_OFS_FLAG_MAIN) ? bus_wdata : 8'h00;
  wire [7:0] clr_rec = wr_hit(bus_wr, bus_addr, `TCM_OFS_FLAG_REC) ? bus_wdata : 8'h00;

  wire dis_nxt = man_wr ? bus_wdata[`TCM_MAN_DISABLE] : disable_req;
  wire cmd_live = man_wr & ~bus_wdata[`TCM_MAN_DISABLE];
  wire w_err = bus_wdata[`TCM_MAN_ERR_REC];
  wire w_fsrc = bus_wdata[`TCM_MAN_FORCE_SOURCE];
  wire w_fsnk = bus_wdata[`TCM_MAN_FORCE_SINK];
  wire w_usrc = bus_wdata[`TCM_MAN_UNATT_SOURCE];
  wire w_usnk = bus_wdata[`TCM_MAN_UNATT_SINK];
  // a forcing command swallowed by a role change counts as failed
  wire frc_drop = cmd_live & portrole_changed & ~w_err & (w_fsrc | w_fsnk);

  wire [7:0] ev_main;
  wire [7:0] ev_rec;
  assign ev_main[7] = 1'h0;
  assign ev_main[`TCM_FM_ORIENT] = (orient_q == `TCM_OR_NONE) &
    ((orientation == `TCM_OR_CC1) | (orientation == `TCM_OR_CC2));
  assign ev_main[`TCM_FM_FAULT] = cc_over_rd_fault & ~fault_q;
  assign ev_main[`TCM_FM_BUSPWR] = pwr_q != {pwr_safe_zero, pwr_valid};
  assign ev_main[`TCM_FM_WEAKBATT] = weak_batt_sink_active ^ weak_q;
  assign ev_main[`TCM_FM_LEVEL] = advertised_current_level != level_q;
  assign ev_main[`TCM_FM_DETACH] = ~attached & attached_q;
  assign ev_main[`TCM_FM_ATTACH] = attached & ~attached_q;
  assign ev_rec[7] = 1'h0;
  assign ev_rec[`TCM_FR_PWR_OFF] = recovery_power_off_req;
  assign ev_rec[`TCM_FR_PWR_UP] = recovery_power_on_req;
  assign ev_rec[4] = 1'h0;
  assign ev_rec[`TCM_FR_REM_BAD] = recovery_failed_in;
  assign ev_rec[`TCM_FR_FRC_BAD] = force_rejected | frc_drop;
  assign ev_rec[`TCM_FR_FRC_OK] = force_executed;
  assign ev_rec[`TCM_FR_REMEDY] = recovery_active & ~remedy_q;

  // soft reset: one pulse, then every register returns to default
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      software_reset_bit <= 1'h0;
    end else begin
      software_reset_bit <= swrst_wr & ~software_reset_bit;
    end
  end

  // manual commands: one-cycle pulses, disable is a held level
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      disable_req <= 1'h0;
      error_recovery_cmd <= 1'h0;
      force_source_cmd <= 1'h0;
      force_sink_cmd <= 1'h0;
      go_unattached_source_cmd <= 1'h0;
      go_unattached_sink_cmd <= 1'h0;
      portrole_apply <= 1'h0;
      role_pend_r <= 1'h0;
    end else if (software_reset_bit) begin
      disable_req <= 1'h0;
      error_recovery_cmd <= 1'h0;
      force_source_cmd <= 1'h0;
      force_sink_cmd <= 1'h0;
      go_unattached_source_cmd <= 1'h0;
      go_unattached_sink_cmd <= 1'h0;
      portrole_apply <= 1'h0;
      role_pend_r <= 1'h0;
    end else begin
      disable_req <= dis_nxt;
      error_recovery_cmd <= 1'h0;
      force_source_cmd <= 1'h0;
      force_sink_cmd <= 1'h0;
      go_unattached_source_cmd <= 1'h0;
      go_unattached_sink_cmd <= 1'h0;
      // role settings wait while disabled, then apply
      portrole_apply <= (portrole_changed | role_pend_r) & ~dis_nxt;
      role_pend_r <= (portrole_changed | role_pend_r) & dis_nxt;
      if (cmd_live && !portrole_changed && w_err) begin
        error_recovery_cmd <= 1'h1;
      end else if (cmd_live && !portrole_changed) begin
        if (w_fsrc) begin
          force_source_cmd <= 1'h1;
        end else if (w_fsnk) begin
          force_sink_cmd <= 1'h1;
        end else if (w_usrc) begin
          go_unattached_source_cmd <= 1'h1;
        end else if (w_usnk) begin
          go_unattached_sink_cmd <= 1'h1;
        end
      end
    end
  end

  // history of the watched status, for edge and change events
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      orient_q <= 2'h0;
      level_q <= 2'h0;
      pwr_q <= 2'h0;
      attached_q <= 1'h0;
      weak_q <= 1'h0;
      fault_q <= 1'h0;
      remedy_q <= 1'h0;
    end else begin
      orient_q <= orientation;
      level_q <= advertised_current_level;
      pwr_q <= {pwr_safe_zero, pwr_valid};
      attached_q <= attached;
      weak_q <= weak_batt_sink_active;
      fault_q <= cc_over_rd_fault;
      remedy_q <= recovery_active;
    end
  end

  // masks and sticky flags
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_main_r <= `TCM_RST_MASK;
      mask_rec_r <= `TCM_RST_MASK;
      flags_main_r <= `TCM_RST_FLAGS;
      flags_rec_r <= `TCM_RST_FLAGS;
    end else if (software_reset_bit) begin
      mask_main_r <= `TCM_RST_MASK;
      mask_rec_r <= `TCM_RST_MASK;
      flags_main_r <= `TCM_RST_FLAGS;
      flags_rec_r <= `TCM_RST_FLAGS;
    end else begin
      if (wr_hit(bus_wr, bus_addr, `TCM_OFS_MASK_MAIN)) begin
        mask_main_r <= bus_wdata & `TCM_MAIN_IMPL;
      end
      if (wr_hit(bus_wr, bus_addr, `TCM_OFS_MASK_REC)) begin
        mask_rec_r <= bus_wdata & `TCM_REC_IMPL;
      end
      flags_main_r <= flag_nxt(flags_main_r, clr_main, ev_main, `TCM_MAIN_IMPL);
      flags_rec_r <= flag_nxt(flags_rec_r, clr_rec, ev_rec, `TCM_REC_IMPL);
    end
  end

  wire [7:0] stat_main = {
    weak_batt_sink_active,
    pwr_safe_zero,
    orientation,
    pwr_valid,
    advertised_current_level,
    attached
  };
  wire [7:0] stat_rec = {6'h00, cc_over_rd_fault, recovery_active};
  wire [7:0] kind = {1'h0, partner_kind};

  // read data follows the pointer; unmapped offsets read zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= 8'h00;
    end else begin
      case (bus_addr)
        `TCM_OFS_MANUAL: rd_data_r <= {6'h00, disable_req, 1'h0};
        `TCM_OFS_SWRST: rd_data_r <= 8'h00;
        `TCM_OFS_MASK_MAIN: rd_data_r <= mask_main_r;
        `TCM_OFS_MASK_REC: rd_data_r <= mask_rec_r;
        `TCM_OFS_STAT_MAIN: rd_data_r <= stat_main;
        `TCM_OFS_STAT_REC: rd_data_r <= stat_rec;
        `TCM_OFS_KIND: rd_data_r <= kind;
        `TCM_OFS_FLAG_MAIN: rd_data_r <= flags_main_r;
        `TCM_OFS_FLAG_REC: rd_data_r <= flags_rec_r;
        default: rd_data_r <= 8'h00;
      endcase
    end
  end

  // masks gate only the pin; flags stay recorded
  wire irq_any = |(flags_main_r & ~mask_main_r) | |(flags_rec_r & ~mask_rec_r);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      int_n_out <= 1'h0;
      int_n_oe <= 1'h0;
    end else begin
      int_n_out <= 1'h0;
      int_n_oe <= irq_any & ~global_irq_mask;
    end
  end
endmodule

// ### dv/tcm_regs_properties.sv
// port assertions for the port controller register bank
`timescale 1ns/10ps
module tcm_regs_properties (
  input logic clk,
  input logic rst,
  input logic sda_out,
  input logic int_n_out,
  input logic int_n_oe,
  input logic portrole_changed,
  input logic global_irq_mask,
  input logic disable_req,
  input logic error_recovery_cmd,
  input logic force_source_cmd,
  input logic force_sink_cmd,
  input logic go_unattached_source_cmd,
  input logic go_unattached_sink_cmd,
  input logic portrole_apply,
  input logic software_reset_bit
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  wire [3:0] role_cmds = {force_source_cmd, force_sink_cmd, go_unattached_source_cmd,
    go_unattached_sink_cmd};
  wire [4:0] cmds = {role_cmds, error_recovery_cmd};
  od_pins_low_a: assert property (sda_out == 1'b0 && int_n_out == 1'b0)
    else $error("open drain data driven high");
  global_mask_gate_a: assert property (
    global_irq_mask && $past(global_irq_mask) |-> !int_n_oe)
    else $error("pin pulled while globally masked");
  cmd_priority_a: assert property ($onehot0(cmds))
    else $error("several commands issued together");
  disable_blocks_cmd_a: assert property (disable_req |-> cmds == 5'h00)
    else $error("command issued while disabled");
  cmd_self_clear_a: assert property (cmds != 5'h00 |=> cmds == 5'h00)
    else $error("command pulse longer than one cycle");
  role_prompt_a: assert property (portrole_changed && !disable_req |=> portrole_apply)
    else $error("role change not applied");
  role_held_a: assert property (disable_req |-> !portrole_apply)
    else $error("role applied while disabled");
  role_beats_cmd_a: assert property (portrole_changed |=> cmds == 5'h00)
    else $error("command issued over a role change");
  soft_reset_clear_a: assert property (
    software_reset_bit |=> !software_reset_bit && !disable_req ##1 !int_n_oe)
    else $error("soft reset left state behind");
endmodule
bind tcm_regs tcm_regs_properties tcm_regs_properties_i (.clk(clk), .rst(rst),
  .sda_out(sda_out), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
  .portrole_changed(portrole_changed), .global_irq_mask(global_irq_mask),
  .disable_req(disable_req), .error_recovery_cmd(error_recovery_cmd),
  .force_source_cmd(force_source_cmd), .force_sink_cmd(force_sink_cmd),
  .go_unattached_source_cmd(go_unattached_source_cmd),
  .go_unattached_sink_cmd(go_unattached_sink_cmd), .portrole_apply(portrole_apply),
  .software_reset_bit(software_reset_bit));

// ### dv/tcm_host_model.sv
// i2c host model that reaches the register bank
`timescale 1ns/10ps
module tcm_host_model #(
  parameter [6:0] ADDR = 7'h21,
  parameter integer H = 4
) (
  input wire clk,
  input wire sda_line,
  output reg scl = 1'b1,
  output reg sda_low = 1'b0
);
  task tick;
    repeat (H) @(posedge clk);
  endtask
  // data set while the clock is low, sampled at the end of the high phase
  task bitx(input logic b, output logic r);
    begin
      sda_low <= !b;
      tick;
      scl <= 1'b1;
      tick;
      r = sda_line;
      scl <= 1'b0;
      tick;
    end
  endtask
  task start;
    begin
      sda_low <= 1'b0;
      scl <= 1'b1;
      tick;
      sda_low <= 1'b1;
      tick;
      scl <= 1'b0;
      tick;
    end
  endtask
  task stop;
    begin
      sda_low <= 1'b1;
      tick;
      scl <= 1'b1;
      tick;
      sda_low <= 1'b0;
      tick;
    end
  endtask
  // ninth bit releases the line for the target's ack
  task put(input logic [7:0] d);
    logic r;
    integer i;
    begin
      for (i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
    end
  endtask
  task get(output logic [7:0] d);
    logic r;
    integer i;
    begin
      for (i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(1'b1, r);
    end
  endtask
  task wr(input logic [7:0] ofs, input logic [7:0] d);
    begin
      start;
      put({ADDR, 1'b0});
      put(ofs);
      put(d);
      stop;
    end
  endtask
  // pointer write, repeated start, one byte ended by a nack
  task rd(input logic [7:0] ofs, output logic [7:0] d);
    begin
      start;
      put({ADDR, 1'b0});
      put(ofs);
      start;
      put({ADDR, 1'b1});
      get(d);
      stop;
    end
  endtask
endmodule

// ### dv/tcm_regs_tb.sv
// self-checking bench for the port controller register bank
`timescale 1ns/10ps
module tcm_regs_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg gm = 1'b0;
  reg clr = 1'b0;
  reg [7:0] st = 8'h00;
  reg [1:0] rs = 2'h0;
  reg [6:0] kind = 7'h00;
  reg [5:0] pu = 6'h00;
  reg [7:0] seen = 8'h00;
  integer errors = 0;
  integer comparisons = 0;
  wire scl, host_low, sda_out, sda_oe, int_n_out, int_n_oe, dis, apply, swr;
  wire [5:0] cv;
  wire sda_line = !(sda_oe || host_low);
  wire [7:0] pin = {7'h00, int_n_oe};
  assign cv[1] = 1'b0;
  tcm_regs tcm_regs_i (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
    .bus_power_safe_zero(st[6]), .bus_power_valid(st[3]), .weak_batt_sink_active(st[7]),
    .orientation(st[5:4]), .advertised_current_level(st[2:1]), .attached(st[0]),
    .partner_kind(kind), .cc_over_rd_fault(rs[1]), .recovery_active(rs[0]),
    .recovery_power_off_req(pu[0]), .recovery_power_on_req(pu[1]),
    .recovery_failed_in(pu[2]), .force_executed(pu[3]), .force_rejected(pu[4]),
    .portrole_changed(pu[5]), .global_irq_mask(gm), .disable_req(dis),
    .error_recovery_cmd(cv[0]), .force_source_cmd(cv[5]), .force_sink_cmd(cv[4]),
    .go_unattached_source_cmd(cv[2]), .go_unattached_sink_cmd(cv[3]),
    .portrole_apply(apply), .software_reset_bit(swr));
  tcm_host_model host_i (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low));
  always #5 clk = ~clk;
  // collects every pulse: commands at their manual register bits, role apply at bit 6, soft reset at bit 7
  always @(posedge clk) seen <= clr ? 8'h00 : (seen | {swr, apply, cv});
  task check(input logic [7:0] v, input logic [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (v !== exp) begin
        errors = errors + 1;
        $display("BAD %0t seen %h expected %h", $time, v, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      if (errors == 0 && comparisons > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task rdchk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] v;
    begin
      host_i.rd(ofs, v);
      check(v, exp);
    end
  endtask
  task flags(input logic [7:0] ofs, input logic [7:0] exp);
    begin
      rdchk(ofs, exp);
      check(pin, {7'h00, exp != 8'h00});
      host_i.wr(ofs, 8'h00);
      rdchk(ofs, exp);
      host_i.wr(ofs, exp);
      rdchk(ofs, 8'h00);
    end
  endtask
  task pulse(input logic [5:0] v);
    begin
      pu <= v;
      @(posedge clk);
      pu <= 6'h00;
    end
  endtask
  task clr_seen;
    begin
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
    end
  endtask
  task t_table;
    logic [7:0] ofs [0:9];
    integer i;
    begin
      ofs = '{8'h09, 8'h0a, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
      for (i = 0; i < 10; i++) rdchk(ofs[i], 8'h00);
    end
  endtask
  task t_manual;
    logic [7:0] wv [0:8];
    logic [7:0] ev [0:8];
    integer i;
    begin
      wv = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h3d, 8'h3c, 8'h1c, 8'h0c};
      ev = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h01, 8'h20, 8'h10, 8'h04};
      for (i = 0; i < 9; i++) begin
        clr_seen;
        host_i.wr(8'h09, wv[i]);
        check(seen, ev[i]);
        rdchk(8'h09, 8'h00);
      end
    end
  endtask
  task t_disable;
    begin
      clr_seen;
      host_i.wr(8'h09, 8'h23);
      pulse(6'h20);
      rdchk(8'h09, 8'h02);
      check({7'h00, dis}, 8'h01);
      check(seen, 8'h00);
      host_i.wr(8'h09, 8'h00);
      check({7'h00, dis}, 8'h00);
      check(seen, 8'h40);
      clr_seen;
      pulse(6'h20);
      repeat (2) @(posedge clk);
      check(seen, 8'h40);
    end
  endtask
  task t_soft;
    begin
      host_i.wr(8'h0e, 8'hff);
      rdchk(8'h0e, 8'h7f);
      host_i.wr(8'h0f, 8'hff);
      rdchk(8'h0f, 8'h6f);
      host_i.wr(8'h11, 8'hff);
      host_i.wr(8'h10, 8'hff);
      host_i.wr(8'h09, 8'h02);
      pulse(6'h08);
      clr_seen;
      host_i.wr(8'h0a, 8'h01);
      check(seen, 8'h80);
      t_table;
    end
  endtask
  task t_main;
    logic [7:0] sv [0:10];
    logic [7:0] fv [0:10];
    integer i;
    begin
      kind <= 7'h10;
      sv = '{8'h11, 8'h01, 8'h31, 8'h01, 8'h21, 8'h27, 8'ha7, 8'h27, 8'h2f, 8'h6f, 8'h00};
      fv = '{8'h41, 8'h00, 8'h00, 8'h00, 8'h40, 8'h04, 8'h08, 8'h08, 8'h10, 8'h10, 8'h16};
      for (i = 0; i < 11; i++) begin
        st <= sv[i];
        rdchk(8'h11, sv[i]);
        flags(8'h14, fv[i]);
      end
      rdchk(8'h13, 8'h10);
    end
  endtask
  task t_rec;
    logic [7:0] fv [0:4];
    integer i;
    begin
      fv = '{8'h40, 8'h20, 8'h08, 8'h02, 8'h04};
      for (i = 0; i < 5; i++) begin
        pulse(6'h01 << i);
        flags(8'h15, fv[i]);
      end
      rs <= 2'h1;
      rdchk(8'h12, 8'h01);
      flags(8'h15, 8'h01);
      rs <= 2'h3;
      rdchk(8'h12, 8'h03);
      flags(8'h14, 8'h20);
    end
  endtask
  task t_mask;
    begin
      host_i.wr(8'h0f, 8'h02);
      pulse(6'h08);
      rdchk(8'h15, 8'h02);
      check(pin, 8'h00);
      host_i.wr(8'h0f, 8'h00);
      check(pin, 8'h01);
      gm <= 1'b1;
      repeat (3) @(posedge clk);
      check(pin, 8'h00);
      gm <= 1'b0;
      host_i.wr(8'h15, 8'h02);
      check(pin, 8'h00);
      check({6'h00, sda_out, int_n_out}, 8'h00);
    end
  endtask
  // a role change landing on the manual write strobe drops every command
  task t_race(input logic [7:0] w, input logic [7:0] fexp);
    integer i;
    begin
      clr_seen;
      fork
        host_i.wr(8'h09, w);
        begin
          for (i = 0; i < 1000 && !tcm_regs_i.bus_wr; i++) @(posedge clk or tcm_regs_i.bus_wr);
          check({7'h00, tcm_regs_i.bus_wr}, 8'h01);
          pulse(6'h20);
        end
      join
      check(seen, 8'h40);
      flags(8'h15, fexp);
    end
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    errors = errors + 1;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_table;
    t_manual;
    t_disable;
    t_soft;
    t_main;
    t_rec;
    t_mask;
    t_race(8'h20, 8'h04);
    t_race(8'h01, 8'h00);
    give_verdict;
  end
endmodule
